// *** verilog/eti_pkg.sv ***
// Package of constants and carrier types for the two-wire EEPROM target interface
package eti_pkg;
	// ============================================================
	// Address byte layout
	// ============================================================
	localparam logic [3:0] ETI_TYPE_CODE    = 4'h5;  // Device-type code, value is arbitrary
	localparam logic [2:0] ETI_FIXED_ADDR   = 3'h1;  // Fixed address bits 0 0 1
	localparam int         ETI_DIR_POS      = 0;     // Direction bit position in address byte
	localparam logic       ETI_DIR_READ     = 1'b1;  // Direction value for a read
	localparam int         ETI_ACK_BIT      = 8;     // Bit index of the ninth clock
	localparam logic [7:0] ETI_RESET_BYTE   = 8'h00; // Reset value of the incoming shift register

	// ============================================================
	// Timing
	// ============================================================
	localparam int ETI_CLK_MHZ        = 100;        // Core clock rate
	localparam int ETI_PU_DELAY_US    = 350;        // Power-up ready delay, 0.35 ms
	localparam int ETI_PU_CYCLES      = ETI_PU_DELAY_US * ETI_CLK_MHZ;
	localparam int ETI_PROG_TIME_US   = 5000;       // Internal program time, 5 ms
	localparam int ETI_PROG_CYCLES    = ETI_PROG_TIME_US * ETI_CLK_MHZ;
	localparam int ETI_FIFO_DEPTH     = 32;         // Data FIFO depth

	// ============================================================
	// Carrier types
	// ============================================================
	typedef struct packed {
		logic [7:0] data;   // Byte value
		logic       first;  // First byte after the address byte
	} eti_byte_t;

	typedef enum logic [2:0] {
		ETI_ST_POWERUP,
		ETI_ST_IDLE,
		ETI_ST_ADDR,
		ETI_ST_WRITE,
		ETI_ST_READ,
		ETI_ST_RD_ACK,
		ETI_ST_IGNORE
	} eti_state_t;
endpackage : eti_pkg

// *** verilog/eti_target.sv ***
// Two-wire EEPROM target interface with its data FIFO
// Summary of operation
// - Standby after power-on, reset while supply low
// - Ready for commands after 0.35 ms
// - Sample on SCL rise, drive after fall
// - Open-drain SDA: pull low for zero
// - START detected; ignore bus before it
// - STOP detected; ends command
// - Match type code and fixed bits
// - Last address bit selects read/write
// - Acknowledge matching address on ninth clock
// - Ack write bytes unless protected or FIFO full; first byte always
// - Read: eight bits, release ninth clock
// - Continue reading while controller acknowledges
// - STOP after a write with an unprotected byte starts programming
// - No address ack while programming
`timescale 1ns/10ps

// ============================================================
// FIFO for received bytes
// ============================================================
module eti_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 32
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	initial begin
		if (DEPTH < 2 || (1 << AW) != DEPTH)
			$error("FIFO depth must be a power of two, at least 2");
	end

	logic [WIDTH-1:0] mem [DEPTH];  // Storage array
	logic [AW:0]      wr_ptr_reg;   // Write pointer with wrap bit
	logic [AW:0]      rd_ptr_reg;   // Read pointer with wrap bit

	// Full when pointers differ only in the wrap bit
	assign in_ready  = !((wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]));
	assign out_valid = (wr_ptr_reg != rd_ptr_reg);
	assign out_data  = mem[rd_ptr_reg[AW-1:0]];

	// Storage write, no reset needed for data
	always_ff @(posedge core_clk) begin
		if (in_valid && in_ready)
			mem[wr_ptr_reg[AW-1:0]] <= in_data;
	end

	// Pointer update
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (in_valid && in_ready)
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			if (out_valid && out_ready)
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
		end
	end
endmodule : eti_fifo

// ============================================================
// Target interface top
// ============================================================
module eti_target
	import eti_pkg::*;
#(
	parameter int PU_CYCLES   = ETI_PU_CYCLES,
	parameter int PROG_CYCLES = ETI_PROG_CYCLES
) (
	input  wire logic  core_clk,
	input  wire logic  rst_b,          // Power-on reset from supply monitor
	input  wire logic  scl_in,
	input  wire logic  sda_in,
	output logic       sda_out,
	output logic       sda_oe,
	input  wire logic  wr_protected,   // Current write byte hits protected area
	output eti_byte_t  rx_byte,        // Received byte toward memory logic
	output logic       rx_valid,
	input  wire logic  rx_ready,
	input  wire logic  tx_valid,       // Read byte from memory logic
	output logic       tx_ready,
	input  wire logic  [7:0] tx_data,
	output logic       write_done,     // Pulse: write command with an unprotected byte closed by STOP
	output logic       busy,           // Ready delay or programming running
	output logic       dir_read        // Current command is a read
);
	initial begin
		if (PU_CYCLES < 1 || PROG_CYCLES < 1)
			$error("Cycle counts must be at least one");
	end

	// ============================================================
	// Pin synchronisers and edge detection
	// ============================================================
	logic [1:0] scl_sync_reg;  // Two-stage SCL synchroniser
	logic [1:0] sda_sync_reg;  // Two-stage SDA synchroniser
	logic       scl_d_reg;     // Delayed synchronised SCL
	logic       sda_d_reg;     // Delayed synchronised SDA

	// Pins come from another domain, double-flop them
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_sync_reg <= 2'h3;
			sda_sync_reg <= 2'h3;
			scl_d_reg    <= 1'b1;
			sda_d_reg    <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[0], scl_in};
			sda_sync_reg <= {sda_sync_reg[0], sda_in};
			scl_d_reg    <= scl_sync_reg[1];
			sda_d_reg    <= sda_sync_reg[1];
		end
	end

	logic scl_s, sda_s, scl_rise, scl_fall, start_det, stop_det;
	assign scl_s     = scl_sync_reg[1];
	assign sda_s     = sda_sync_reg[1];
	assign scl_rise  = scl_s && !scl_d_reg;
	assign scl_fall  = !scl_s && scl_d_reg;
	assign start_det = scl_s && scl_d_reg && sda_d_reg && !sda_s;
	assign stop_det  = scl_s && scl_d_reg && !sda_d_reg && sda_s;

	// ============================================================
	// Power-up and programming timers
	// ============================================================
	logic [$clog2(PU_CYCLES+1)-1:0]   pu_cnt_reg;    // Ready delay counter
	logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_reg;  // Programming cycle counter
	logic                             pu_done;
	logic                             prog_busy;
	logic                             launch_prog;

	assign pu_done   = (pu_cnt_reg == '0);
	assign prog_busy = (prog_cnt_reg != '0);
	assign busy      = !pu_done || prog_busy;

	// Reset holds the interface dead; count down to standby after release
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			pu_cnt_reg <= $bits(pu_cnt_reg)'(PU_CYCLES);
		else if (!pu_done)
			pu_cnt_reg <= pu_cnt_reg - 1'b1;
	end

	// Programming runs a fixed time after a write STOP
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			prog_cnt_reg <= '0;
		else if (launch_prog)
			prog_cnt_reg <= $bits(prog_cnt_reg)'(PROG_CYCLES);
		else if (prog_busy)
			prog_cnt_reg <= prog_cnt_reg - 1'b1;
	end

	// ============================================================
	// Bit engine
	// ============================================================
	eti_state_t state_reg;        // Protocol state
	logic [3:0] bit_cnt_reg;      // Clock index within the byte, 0..8; F before first clock
	logic [7:0] shift_reg;        // Incoming byte
	logic [7:0] tx_shift_reg;     // Outgoing byte
	logic       first_reg;        // Next received byte is the first data byte
	logic       ack_reg;          // Drive acknowledge in ninth clock
	logic       wrote_reg;        // An unprotected write byte was received
	logic       dir_reg;          // Read command flag
	logic       sda_low_reg;      // Drive SDA low
	logic [7:0] rx_full;
	logic       addr_match;
	logic       push;

	assign rx_full    = {shift_reg[6:0], sda_s};
	// Only the upper seven bits identify the target; bit 0 is direction
	assign addr_match = (rx_full[7:4] == ETI_TYPE_CODE) && (rx_full[3:1] == ETI_FIXED_ADDR);
	assign push       = (state_reg == ETI_ST_WRITE) && scl_rise && (bit_cnt_reg == 4'h7);
	assign launch_prog = stop_det && wrote_reg && (state_reg != ETI_ST_POWERUP);
	assign write_done = launch_prog;
	assign dir_read   = dir_reg;

	// Main sequencer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= ETI_ST_POWERUP;
			bit_cnt_reg <= 4'h0;
			shift_reg   <= ETI_RESET_BYTE;
			first_reg   <= 1'b0;
			dir_reg     <= 1'b0;
			wrote_reg   <= 1'b0;
		end else if (state_reg == ETI_ST_POWERUP) begin
			if (pu_done)
				state_reg <= ETI_ST_IDLE;
		end else if (start_det) begin
			// Restart abandons any byte in flight
			state_reg   <= ETI_ST_ADDR;
			// Parked one below zero: the START's own SCL fall brings it to 0
			bit_cnt_reg <= 4'hF;
			wrote_reg   <= 1'b0;
		end else if (stop_det) begin
			state_reg   <= ETI_ST_IDLE;
			bit_cnt_reg <= 4'h0;
			wrote_reg   <= 1'b0;
			dir_reg     <= 1'b0;
		end else begin
			if (scl_rise) begin
				shift_reg <= rx_full;
				if (push) begin
					first_reg <= 1'b0;
					wrote_reg <= wrote_reg || !wr_protected;
				end
			end
			if (scl_fall && state_reg != ETI_ST_IDLE && state_reg != ETI_ST_IGNORE)
				bit_cnt_reg <= (bit_cnt_reg == 4'(ETI_ACK_BIT)) ? 4'h0 : bit_cnt_reg + 4'h1;
			unique case (state_reg)
				ETI_ST_IDLE, ETI_ST_IGNORE, ETI_ST_POWERUP: begin
					// Nothing on the bus counts until START
				end
				ETI_ST_ADDR: begin
					if (scl_rise && bit_cnt_reg == 4'h7) begin
						if (!addr_match || prog_busy)
							state_reg <= ETI_ST_IGNORE;
						else begin
							dir_reg   <= rx_full[ETI_DIR_POS];
							first_reg <= 1'b1;
						end
					end
					if (scl_fall && bit_cnt_reg == 4'(ETI_ACK_BIT))
						state_reg <= dir_reg ? ETI_ST_READ : ETI_ST_WRITE;
				end
				ETI_ST_WRITE: begin
				end
				ETI_ST_READ: begin
					if (scl_fall && bit_cnt_reg == 4'h7)
						state_reg <= ETI_ST_RD_ACK;
				end
				ETI_ST_RD_ACK: begin
					// Controller ack keeps data flowing, no-ack waits for STOP
					if (scl_rise)
						state_reg <= sda_s ? ETI_ST_IGNORE : ETI_ST_READ;
				end
			endcase
		end
	end

	// ============================================================
	// Acknowledge decision
	// ============================================================
	// Decided at the eighth rising edge, held through the ninth clock
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			ack_reg <= 1'b0;
		else if (start_det || stop_det)
			ack_reg <= 1'b0;
		else if (scl_rise && bit_cnt_reg == 4'h7) begin
			if (state_reg == ETI_ST_ADDR)
				ack_reg <= addr_match && !prog_busy;
			else if (state_reg == ETI_ST_WRITE)
				ack_reg <= first_reg || (!wr_protected && rx_in_ready);
			else
				ack_reg <= 1'b0;
		end else if (scl_fall && bit_cnt_reg == 4'(ETI_ACK_BIT))
			ack_reg <= 1'b0;
	end

	// ============================================================
	// Read data path
	// ============================================================
	logic load_tx;
	// Load a fresh byte as the address byte's ninth clock ends; later read bytes load at an acknowledged ninth rise
	assign load_tx  = scl_fall && (((state_reg == ETI_ST_ADDR) && dir_reg && bit_cnt_reg == 4'(ETI_ACK_BIT))
	                  || ((state_reg == ETI_ST_RD_ACK) && 1'b0));
	assign tx_ready = load_tx || (state_reg == ETI_ST_READ && scl_fall && bit_cnt_reg == 4'h0 && 1'b0)
	                  || (state_reg == ETI_ST_RD_ACK && scl_rise && !sda_s);

	// Outgoing shift; empty source sends all ones, which reads as released
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			tx_shift_reg <= 8'hFF;
		else if (tx_ready)
			tx_shift_reg <= tx_valid ? tx_data : 8'hFF;
		else if (state_reg == ETI_ST_READ && scl_fall && bit_cnt_reg < 4'h7)
			tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
	end

	// ============================================================
	// SDA drive
	// ============================================================
	// Driven only after SCL falls so data is stable while SCL high
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b)
			sda_low_reg <= 1'b0;
		else if (start_det || stop_det)
			sda_low_reg <= 1'b0;
		else if (scl_fall) begin
			if (state_reg == ETI_ST_ADDR && bit_cnt_reg == 4'h7)
				sda_low_reg <= ack_reg;
			else if (state_reg == ETI_ST_WRITE && bit_cnt_reg == 4'h7)
				sda_low_reg <= ack_reg;
			else if (state_reg == ETI_ST_ADDR && bit_cnt_reg == 4'(ETI_ACK_BIT) && dir_reg)
				sda_low_reg <= tx_valid ? !tx_data[7] : 1'b0;
			else if (state_reg == ETI_ST_READ && bit_cnt_reg == 4'(ETI_ACK_BIT))
				sda_low_reg <= !tx_shift_reg[7];
			else if (state_reg == ETI_ST_READ && bit_cnt_reg != 4'h7)
				sda_low_reg <= !tx_shift_reg[6];
			else
				sda_low_reg <= 1'b0;
		end else if (state_reg == ETI_ST_RD_ACK && scl_rise && !sda_s)
			sda_low_reg <= 1'b0;
	end

	// Release for one, pull low for zero
	assign sda_out = 1'b0;
	assign sda_oe  = sda_low_reg;

	// ============================================================
	// Receive FIFO
	// ============================================================
	eti_byte_t rx_in;
	logic      rx_in_ready;
	assign rx_in.data  = rx_full;
	assign rx_in.first = first_reg;

	eti_fifo #(
		.WIDTH ($bits(eti_byte_t)),
		.DEPTH (ETI_FIFO_DEPTH)
	) u_rx_fifo (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.flush     (1'b0),
		.in_valid  (push && (first_reg || !wr_protected)),
		.in_ready  (rx_in_ready),
		.in_data   (rx_in),
		.out_valid (rx_valid),
		.out_ready (rx_ready),
		.out_data  (rx_byte)
	);
endmodule : eti_target

// *** tb/eti_target_asserts.sv ***
// Checker of pin timing and handshakes of the two-wire target interface
`timescale 1ns/10ps
// ============================================================
// Checker module
// ============================================================
module eti_target_asserts
	import eti_pkg::*;
#(
	parameter int PU_CYCLES = 20  // Ready delay in core cycles
) (
	input wire logic      core_clk,
	input wire logic      rst_b,
	input wire logic      scl_in,
	input wire logic      sda_in,
	input wire logic      sda_out,
	input wire logic      sda_oe,
	input wire eti_byte_t rx_byte,
	input wire logic      rx_valid,
	input wire logic      rx_ready,
	input wire logic      tx_ready,
	input wire logic      write_done,
	input wire logic      busy
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	int up_reg;  // Cycles since reset release, saturates
	// Count only up to the delay so the counter never wraps
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			up_reg <= 0;
		end else if (up_reg < PU_CYCLES) begin
			up_reg <= up_reg + 1;
		end
	end
	// Bus conditions on the raw pins
	sequence s_start; scl_in && $past(scl_in) && $fell(sda_in); endsequence
	sequence s_stop; scl_in && sda_in; endsequence
	property p_low_only; sda_out == 1'h0; endproperty
	property p_rise_scl_low; $rose(sda_oe) |-> !scl_in; endproperty
	property p_hold_scl_high; $rose(scl_in) |-> $stable(sda_oe) [*4]; endproperty
	property p_ready_delay; up_reg < PU_CYCLES - 1 |-> busy; endproperty
	property p_standby; $rose(rst_b) |-> busy && !sda_oe; endproperty
	property p_no_ack_busy; $rose(sda_oe) |-> !busy; endproperty
	property p_done_prog; write_done |=> !write_done && busy; endproperty
	property p_done_stop; write_done |-> s_stop; endproperty
	property p_start_quiet; s_start |-> !sda_oe [*8]; endproperty
	property p_rx_hold; rx_valid && !rx_ready |=> rx_valid && $stable(rx_byte); endproperty
	property p_tx_pulse; tx_ready |=> !tx_ready; endproperty
	a_low_only: assert property (p_low_only) else $error("sda driven high");
	a_rise_scl_low: assert property (p_rise_scl_low) else $error("sda drive while scl high");
	a_hold_scl_high: assert property (p_hold_scl_high) else $error("sda drive moved at scl rise");
	a_ready_delay: assert property (p_ready_delay) else $error("ready too early");
	a_standby: assert property (p_standby) else $error("bad state after reset");
	a_no_ack_busy: assert property (p_no_ack_busy) else $error("ack while programming");
	a_done_prog: assert property (p_done_prog) else $error("programming not started");
	a_done_stop: assert property (p_done_stop) else $error("write done without stop");
	a_start_quiet: assert property (p_start_quiet) else $error("drive during address");
	a_rx_hold: assert property (p_rx_hold) else $error("rx byte lost");
	a_tx_pulse: assert property (p_tx_pulse) else $error("tx ready too long");
endmodule : eti_target_asserts

bind eti_target eti_target_asserts #(.PU_CYCLES(PU_CYCLES)) u_chk (
	.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .rx_byte(rx_byte), .rx_valid(rx_valid),
	.rx_ready(rx_ready), .tx_ready(tx_ready), .write_done(write_done), .busy(busy));

// *** tb/eti_master_model.sv ***
// Behavioural bus controller driving the clock and all bus conditions
`timescale 1ns/10ps
// ============================================================
// Controller model
// ============================================================
module eti_master_model (
	input  wire logic core_clk,
	input  wire logic sda,
	output logic      scl,
	output logic      sda_low
);
	// Clock stands high, data released: bus free between frames
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end
	// Quarter of a 160 ns bit
	task automatic qtr(input int n);
		repeat (4 * n) @(negedge core_clk);
	endtask : qtr
	// Release, let bus settle, then pull data low with clock high
	task automatic start();
		sda_low = 1'h0;
		qtr(2);
		scl = 1'h1;
		qtr(2);
		sda_low = 1'h1;
		qtr(1);
		scl = 1'h0;
	endtask : start
	// Data released with clock high, bus left idle
	task automatic stop();
		sda_low = 1'h1;
		qtr(1);
		scl = 1'h1;
		qtr(1);
		sda_low = 1'h0;
		qtr(2);
	endtask : stop
	// n bits MSB first; a full byte adds the ninth bit at level ai
	task automatic xbyte(input logic [7:0] d, input int n, input logic ai, output logic [7:0] r, output logic ao);
		logic [8:0] v;
		v = {d, ai};
		r = 8'h00;
		for (int i = 0; i < n + (n == 8); i++) begin
			sda_low = !v[8 - i];
			qtr(1);
			scl = 1'h1;
			qtr(1);
			if (i < 8) r = {r[6:0], sda};
			else ao = sda;
			qtr(1);
			scl = 1'h0;
			qtr(1);
		end
	endtask : xbyte
endmodule : eti_master_model

// *** tb/testbench.sv ***
// Self-checking bench for the two-wire target interface
`timescale 1ns/10ps
// ============================================================
// Bench top
// ============================================================
module testbench;
	import eti_pkg::*;
	logic       core_clk = 1'h0;      // Core clock
	logic       rst_b = 1'h0;         // Supply monitor reset
	logic       wr_protected = 1'h0;  // Protected-area flag
	logic       rx_ready = 1'h0;      // Consumer stalled at first
	logic       tx_valid = 1'h0;      // Memory side offer
	logic [7:0] tx_data = 8'h00;
	logic       tx_taken = 1'h0;      // Byte was taken at the last edge
	wire        scl;                  // Controller clock
	wire        m_low;                // Controller pulls data
	wire        sda;                  // Resolved data wire
	eti_byte_t  rx_byte;
	logic       sda_out, sda_oe, rx_valid, tx_ready, write_done, busy, dir_read;
	int         err_total = 0, cmp_count = 0, wd_cnt = 0, seed = 3452;
	logic [8:0] exp_q[$];             // Bytes the consumer must see
	logic [7:0] rd_q[$];              // Bytes taken by the device for reading
	logic [7:0] r, d;
	logic       a;
	logic [7:0] bad[2] = '{{ETI_TYPE_CODE, 3'h3, 1'h0}, {~ETI_TYPE_CODE, ETI_FIXED_ADDR, 1'h1}};
	// Pull-up wins unless a party pulls low
	assign sda = (m_low || (sda_oe && !sda_out)) ? 1'h0 : 1'h1;
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	eti_master_model MST (.core_clk(core_clk), .sda(sda), .scl(scl), .sda_low(m_low));
	// Short counts keep the run brief; program time outlasts one poll
	eti_target #(.PU_CYCLES(20), .PROG_CYCLES(400)) DUT (
		.core_clk(core_clk), .rst_b(rst_b), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .wr_protected(wr_protected), .rx_byte(rx_byte), .rx_valid(rx_valid),
		.rx_ready(rx_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
		.write_done(write_done), .busy(busy), .dir_read(dir_read));
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check
	task automatic tally_and_finish();
		$display("Compares %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	// Bounded wait for busy to drop
	task automatic wait_idle();
		int n;
		for (n = 0; n < 2000 && busy !== 1'h0; n++) @(negedge core_clk);
		if (n == 2000) begin
			err_total++;
			tally_and_finish();
		end
	endtask : wait_idle
	// START plus own address; ack level left in a
	task automatic addr(input logic rd);
		MST.start();
		MST.xbyte({ETI_TYPE_CODE, ETI_FIXED_ADDR, rd}, 8, 1'h1, r, a);
	endtask : addr
	task automatic wbyte(input logic [7:0] v, input logic ack_level);
		MST.xbyte(v, 8, 1'h1, r, a);
		check(a, ack_level);
	endtask : wbyte
	// Consumer pops in order while enabled
	always @(negedge core_clk) begin
		if (rx_ready && rx_valid === 1'h1 && exp_q.size() > 0) check(rx_byte, exp_q.pop_front());
	end
	// Memory side: offer held until the taking edge has passed; count write closes
	always @(negedge core_clk) begin
		if (tx_taken) tx_data = $random(seed);
		tx_taken = (tx_ready === 1'h1);
		if (tx_taken) rd_q.push_back(tx_data);
		if (write_done === 1'h1) wd_cnt++;
	end
	initial begin
		repeat (16) @(negedge core_clk);
		rst_b = 1'h1;
		tx_valid = 1'h1;
		repeat (5) @(negedge core_clk);
		check(busy, 1'h1);
		wait_idle();
		foreach (bad[i]) begin
			MST.start();
			MST.xbyte(bad[i], 8, 1'h1, r, a);
			check(a, 1'h1);
			MST.stop();
		end
		$display("test reset and address match done");
		addr(1'h0);
		check(a, 1'h0);
		check(dir_read, 1'h0);
		for (int i = 0; i < 33; i++) begin
			d = $random(seed);
			if (i < 32) exp_q.push_back({d, i == 0});
			wbyte(d, i == 32);
		end
		MST.stop();
		repeat (6) @(negedge core_clk);
		check(9'(wd_cnt), 9'h001);
		addr(1'h0);
		check(a, 1'h1);
		MST.stop();
		rx_ready = 1'h1;
		wait_idle();
		check(9'(exp_q.size()), 9'h000);
		$display("test fill and poll done");
		addr(1'h1);
		check(a, 1'h0);
		check(dir_read, 1'h1);
		for (int i = 0; i < 3; i++) begin
			MST.xbyte(8'hFF, 8, i == 2, r, a);
			check(r, rd_q.pop_front());
			check(a, i == 2);
		end
		MST.stop();
		check(9'(rd_q.size()), 9'h000);
		$display("test read done");
		addr(1'h0);
		MST.xbyte(8'hA5, 4, 1'h1, r, a);
		addr(1'h0);
		check(a, 1'h0);
		d = $random(seed);
		exp_q.push_back({d, 1'h1});
		wbyte(d, 1'h0);
		MST.stop();
		wait_idle();
		addr(1'h0);
		d = $random(seed);
		exp_q.push_back({d, 1'h1});
		wbyte(d, 1'h0);
		wr_protected = 1'h1;
		wbyte(8'h3C, 1'h1);
		wr_protected = 1'h0;
		MST.stop();
		repeat (40) @(negedge core_clk);
		check(9'(wd_cnt), 9'h003);
		check(9'(exp_q.size()), 9'h000);
		$display("test abort and protect done");
		// Supply dip mid-run: back to the power-up wait, then answers again
		rst_b = 1'h0;
		repeat (3) @(negedge core_clk);
		check(busy, 1'h1);
		check(sda_oe, 1'h0);
		rst_b = 1'h1;
		repeat (5) @(negedge core_clk);
		check(busy, 1'h1);
		wait_idle();
		addr(1'h0);
		check(a, 1'h0);
		MST.stop();
		$display("test supply dip done");
		tally_and_finish();
	end
endmodule : testbench
